// ===== common/spsf_params.svh
`ifndef SPSF_PARAMS_SVH
`define SPSF_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SPSF_OFS_STATUS 12'h000
`define SPSF_OFS_CONTROL 12'h004
`define SPSF_OFS_MCTRL 12'h008
`define SPSF_OFS_SHIFT_BUFFER 12'h00C
`define SPSF_OFS_IRQ_STATUS 12'h010
`define SPSF_OFS_IRQ_MASK 12'h014
`define SPSF_OFS_SLAVE_ADDR 12'h018

// ----------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------
`define SPSF_ST_BF 0
`define SPSF_ST_UA 1
`define SPSF_ST_RW 2
`define SPSF_ST_START 3
`define SPSF_ST_STOP 4
`define SPSF_ST_DA 5
`define SPSF_ST_CKE 6
`define SPSF_ST_SMP 7

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SPSF_CT_EN 0
`define SPSF_CT_MODE_LO 1
`define SPSF_CT_MODE_HI 2
`define SPSF_CT_TEN_BIT 3

// ----------------------------------------------------------------
// Interrupt status bit positions
// ----------------------------------------------------------------
`define SPSF_IRQ_RX 0
`define SPSF_IRQ_TX 1
`define SPSF_IRQ_START 2
`define SPSF_IRQ_STOP 3
`define SPSF_IRQ_UA 4
`define SPSF_IRQ_W 5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SPSF_RST_STATUS 8'h00
`define SPSF_RST_CONTROL 4'h0
`define SPSF_RST_MCTRL 5'h0
`define SPSF_RST_IRQ 5'h0
`define SPSF_RST_SLAVE_ADDR 10'h0

`endif

// ===== common/spsf_pkg.sv
package spsf_pkg;

    // Port operating mode, as held in the control register
    typedef enum logic [1:0] {
        SPSF_SPI_MASTER = 2'h0,
        SPSF_SPI_SLAVE = 2'h1,
        SPSF_I2C_MASTER = 2'h2,
        SPSF_I2C_SLAVE = 2'h3
    } spsf_mode_e;

    // Transmit byte tracking, Gray coded along idle-loaded-shifting
    typedef enum logic [1:0] {
        SPSF_TX_IDLE = 2'h0,
        SPSF_TX_LOADED = 2'h1,
        SPSF_TX_SHIFTING = 2'h3
    } spsf_tx_state_e;

    typedef logic [7:0] spsf_byte_t;

endpackage

// ===== design/spsf_top.sv
// Our own choices: the register offsets and the APB interface to the registers.
`include "spsf_params.svh"

// What this block does
// - In I2C, data/address flag reads 1 after data byte, 0 after address.
// - I2C slave direction flag takes address match read/write bit, clears on start, stop or ack.
// - I2C master idle only when transmit and sequence enables are all zero.
// - Address update flag set only in 10-bit I2C, cleared when not needed.
// - Buffer full sets on a complete received byte, clears when empty.
// - I2C transmit holds buffer full during eight data bits only.
// - Start and stop flags clear on reset and when port is disabled.
// - SPI master sample-phase bit picks end or middle input sampling.
module spsf_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic ev_start,
    input wire logic ev_stop,
    input wire logic ev_ack,
    input wire logic ev_addr_match,
    input wire logic ev_addr_rw,
    input wire logic ev_addr_high,
    input wire logic rx_valid,
    input wire logic rx_is_data,
    input wire spsf_pkg::spsf_byte_t rx_byte,
    input wire logic tx_begin,
    input wire logic tx_bits_done,
    input wire logic tx_is_data,
    input wire logic [4:0] seq_done,
    output spsf_pkg::spsf_byte_t tx_byte,
    output logic tx_pending,
    output logic port_enable_bit,
    output spsf_pkg::spsf_mode_e port_mode,
    output logic [9:0] slave_address_register,
    output logic [4:0] seq_enable,
    output logic tx_on_active_to_idle,
    output logic sample_at_end,
    output logic master_idle
);
    import spsf_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] status;
    logic [7:0] next_status;
    logic [3:0] control;
    logic [3:0] next_control;
    logic [4:0] mctrl;
    logic [4:0] next_mctrl;
    spsf_byte_t shift_buffer;
    spsf_byte_t next_shift_buffer;
    spsf_byte_t tx_hold;
    spsf_byte_t next_tx_hold;
    logic [4:0] irq_status;
    logic [4:0] next_irq_status;
    logic [4:0] irq_mask;
    logic [4:0] next_irq_mask;
    logic [9:0] slave_addr;
    logic [9:0] next_slave_addr;
    spsf_tx_state_e tx_state;
    spsf_tx_state_e next_tx_state;
    logic [31:0] next_prdata;

    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic mapped;
    logic is_i2c;
    logic is_spi;
    logic [4:0] irq_set;
    logic [4:0] irq_clr;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wr = access & pwrite;
    assign rd = access & ~pwrite;
    assign pready = 1'b1; // Every access completes in its first cycle
    assign pslverr = access & ~mapped;

    // Address map check
    always_comb
    begin
        case (paddr)
            `SPSF_OFS_STATUS, `SPSF_OFS_CONTROL, `SPSF_OFS_MCTRL,
            `SPSF_OFS_SHIFT_BUFFER, `SPSF_OFS_IRQ_STATUS,
            `SPSF_OFS_IRQ_MASK, `SPSF_OFS_SLAVE_ADDR: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Outputs to the shift engine
    // ------------------------------------------------------------
    assign port_enable_bit = control[`SPSF_CT_EN];
    assign port_mode =
        spsf_mode_e'(control[`SPSF_CT_MODE_HI:`SPSF_CT_MODE_LO]);
    assign is_i2c = control[`SPSF_CT_MODE_HI];
    assign is_spi = ~control[`SPSF_CT_MODE_HI];
    assign slave_address_register = slave_addr;
    assign seq_enable = mctrl;
    assign tx_byte = tx_hold;
    assign tx_pending = (tx_state == SPSF_TX_LOADED);
    // Edge select applies to both SPI roles
    assign tx_on_active_to_idle = is_spi & status[`SPSF_ST_CKE];
    // Sample phase only matters for an SPI master
    assign sample_at_end = (port_mode == SPSF_SPI_MASTER)
        & status[`SPSF_ST_SMP];
    // Idle when no transfer and no sequence enable is pending
    assign master_idle = ~(status[`SPSF_ST_RW] | (|mctrl));
    assign irq = |(irq_status & irq_mask);

    // Events that raise sticky interrupt bits
    always_comb
    begin
        irq_set = '0;
        irq_set[`SPSF_IRQ_RX] = rx_valid & port_enable_bit;
        irq_set[`SPSF_IRQ_TX] = tx_bits_done & port_enable_bit;
        irq_set[`SPSF_IRQ_START] = ev_start & port_enable_bit;
        irq_set[`SPSF_IRQ_STOP] = ev_stop & port_enable_bit;
        irq_set[`SPSF_IRQ_UA] = ev_addr_match & ev_addr_high & is_i2c
            & control[`SPSF_CT_TEN_BIT] & port_enable_bit;
        irq_clr = '0;
        if (wr && paddr == `SPSF_OFS_IRQ_STATUS)
        begin
            irq_clr = pwdata[`SPSF_IRQ_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Next-state logic for all registers
    // ------------------------------------------------------------
    always_comb
    begin
        next_status = status;
        next_control = control;
        next_mctrl = mctrl;
        next_shift_buffer = shift_buffer;
        next_tx_hold = tx_hold;
        next_irq_mask = irq_mask;
        next_slave_addr = slave_addr;
        next_tx_state = tx_state;
        next_prdata = prdata;
        // Sticky bits: set beats a same-cycle clear
        next_irq_status = (irq_status & ~irq_clr) | irq_set;

        // Software writes
        if (wr)
        begin
            case (paddr)
                `SPSF_OFS_STATUS:
                begin
                    next_status[`SPSF_ST_SMP] = pwdata[`SPSF_ST_SMP];
                    next_status[`SPSF_ST_CKE] = pwdata[`SPSF_ST_CKE];
                end
                `SPSF_OFS_CONTROL: next_control = pwdata[3:0];
                `SPSF_OFS_MCTRL: next_mctrl = mctrl | pwdata[4:0];
                `SPSF_OFS_SHIFT_BUFFER:
                begin
                    next_tx_hold = pwdata[7:0];
                    next_tx_state = SPSF_TX_LOADED;
                    if (is_i2c)
                    begin
                        next_status[`SPSF_ST_BF] = 1'b1;
                    end
                end
                `SPSF_OFS_IRQ_MASK: next_irq_mask = pwdata[4:0];
                `SPSF_OFS_SLAVE_ADDR:
                begin
                    next_slave_addr = pwdata[9:0];
                    next_status[`SPSF_ST_UA] = 1'b0;
                end
                default: next_control = control;
            endcase
        end

        // Reading the receive byte empties the buffer when tx_state is idle
        if (rd && paddr == `SPSF_OFS_SHIFT_BUFFER
            && tx_state == SPSF_TX_IDLE)
        begin
            next_status[`SPSF_ST_BF] = 1'b0;
        end

        // Sequence enables drop as the engine finishes each one
        next_mctrl = next_mctrl & ~seq_done;

        // Engine events, applied after software so that they win
        if (rx_valid)
        begin
            next_shift_buffer = rx_byte;
            next_status[`SPSF_ST_BF] = 1'b1;
        end
        if (is_i2c && (rx_valid || tx_bits_done))
        begin
            next_status[`SPSF_ST_DA] =
                rx_valid ? rx_is_data : tx_is_data;
        end

        // Transmit tracking
        case (tx_state)
            SPSF_TX_IDLE: next_tx_state = next_tx_state;
            SPSF_TX_LOADED:
            begin
                if (tx_begin)
                begin
                    next_tx_state = SPSF_TX_SHIFTING;
                end
            end
            SPSF_TX_SHIFTING:
            begin
                if (tx_bits_done)
                begin
                    next_tx_state = SPSF_TX_IDLE;
                    if (is_i2c)
                    begin
                        // Ack and stop bits are outside this window
                        next_status[`SPSF_ST_BF] = 1'b0;
                    end
                end
            end
            default: next_tx_state = SPSF_TX_IDLE;
        endcase

        // Direction flag
        if (port_mode == SPSF_I2C_SLAVE)
        begin
            if (ev_addr_match)
            begin
                next_status[`SPSF_ST_RW] = ev_addr_rw;
            end
            else if (ev_start || ev_stop || ev_ack)
            begin
                next_status[`SPSF_ST_RW] = 1'b0;
            end
        end
        else if (port_mode == SPSF_I2C_MASTER)
        begin
            // Master: flag shows a transmit in progress
            next_status[`SPSF_ST_RW] =
                (next_tx_state == SPSF_TX_SHIFTING);
        end
        else
        begin
            next_status[`SPSF_ST_RW] = 1'b0;
        end

        // Address update request, 10-bit I2C only
        if (is_i2c && control[`SPSF_CT_TEN_BIT])
        begin
            if (ev_addr_match && ev_addr_high)
            begin
                next_status[`SPSF_ST_UA] = 1'b1;
            end
        end
        else
        begin
            next_status[`SPSF_ST_UA] = 1'b0;
        end

        // Start and stop detection
        if (ev_start)
        begin
            next_status[`SPSF_ST_START] = 1'b1;
            next_status[`SPSF_ST_STOP] = 1'b0;
        end
        if (ev_stop)
        begin
            next_status[`SPSF_ST_STOP] = 1'b1;
            next_status[`SPSF_ST_START] = 1'b0;
        end
        if (!next_control[`SPSF_CT_EN])
        begin
            next_status[`SPSF_ST_START] = 1'b0;
            next_status[`SPSF_ST_STOP] = 1'b0;
        end

        // Read data captured in the setup cycle
        if (setup)
        begin
            case (paddr)
                `SPSF_OFS_STATUS: next_prdata = {24'h000000, status};
                `SPSF_OFS_CONTROL: next_prdata = {28'h0000000, control};
                `SPSF_OFS_MCTRL: next_prdata = {27'h0, mctrl};
                `SPSF_OFS_SHIFT_BUFFER:
                    next_prdata = {24'h000000, shift_buffer};
                `SPSF_OFS_IRQ_STATUS:
                    next_prdata = {27'h0, irq_status};
                `SPSF_OFS_IRQ_MASK: next_prdata = {27'h0, irq_mask};
                `SPSF_OFS_SLAVE_ADDR:
                    next_prdata = {22'h0, slave_addr};
                default: next_prdata = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Asynchronous reset clears all flags, start and stop included
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status <= `SPSF_RST_STATUS;
            control <= `SPSF_RST_CONTROL;
            mctrl <= `SPSF_RST_MCTRL;
            shift_buffer <= 8'h00;
            tx_hold <= 8'h00;
            irq_status <= `SPSF_RST_IRQ;
            irq_mask <= `SPSF_RST_IRQ;
            slave_addr <= `SPSF_RST_SLAVE_ADDR;
            tx_state <= SPSF_TX_IDLE;
            prdata <= 32'h00000000;
        end
        else
        begin
            status <= next_status;
            control <= next_control;
            mctrl <= next_mctrl;
            shift_buffer <= next_shift_buffer;
            tx_hold <= next_tx_hold;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            slave_addr <= next_slave_addr;
            tx_state <= next_tx_state;
            prdata <= next_prdata;
        end
    end

endmodule

// ===== dv/serial_port_status_flags_bench.sv
// ----------------------------------------
// Status flag bench
// ----------------------------------------
module serial_port_status_flags_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import spsf_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq, perr, ev_start, ev_stop, ev_ack;
    logic ev_addr_match, ev_addr_rw, ev_addr_high, rx_valid, rx_is_data;
    logic tx_begin, tx_bits_done, tx_is_data, tx_pending, port_enable_bit;
    logic tx_on_active_to_idle, sample_at_end, master_idle;
    spsf_byte_t rx_byte, tx_byte;
    spsf_mode_e port_mode;
    logic [4:0] seq_done, seq_enable;
    logic [9:0] slave_address_register;
    int n_fail = 0;
    int total_checks = 0;
    always #2 pclk = ~pclk;
    spsf_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq, .ev_start, .ev_stop, .ev_ack,
        .ev_addr_match, .ev_addr_rw, .ev_addr_high, .rx_valid, .rx_is_data,
        .rx_byte, .tx_begin, .tx_bits_done, .tx_is_data, .seq_done, .tx_byte,
        .tx_pending, .port_enable_bit, .port_mode, .slave_address_register,
        .seq_enable, .tx_on_active_to_idle, .sample_at_end, .master_idle);
    spsf_engine_model eng (.pclk, .ev_start, .ev_stop, .ev_ack,
        .ev_addr_match, .ev_addr_rw, .ev_addr_high, .rx_valid, .rx_is_data,
        .rx_byte, .tx_begin, .tx_bits_done, .tx_is_data, .seq_done);
    // Verdict and stop
    task end_of_test;
        if (n_fail == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task check(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    // One APB transfer, waiting on pready under a bound
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
        if (n >= 16)
        begin
            n_fail++;
            end_of_test;
        end
    endtask
    // Read status and compare the masked bits
    task st(input logic [7:0] m, input logic [7:0] e);
        apb(1'b0, 12'h000, 32'h0);
        check("status", {24'h0, e}, rd & {24'h0, m});
    endtask
    task t_reset;
        st(8'hFF, 8'h00);
        check("master_idle", 1, master_idle);
    endtask
    task t_rx;
        apb(1'b1, 12'h004, 32'h7);
        eng.rx(8'h5A, 1'b1);
        st(8'h21, 8'h21);
        check("irq", 0, irq);
        apb(1'b1, 12'h014, 32'h1);
        check("irq", 1, irq);
        apb(1'b0, 12'h00C, 32'h0);
        check("shift_buffer", 32'h5A, rd);
        st(8'h01, 8'h00);
        eng.rx(8'h3C, 1'b0);
        st(8'h21, 8'h01);
        apb(1'b1, 12'h010, 32'h1);
        check("irq", 0, irq);
    endtask
    task t_rw;
        eng.addr(1'b1, 1'b0);
        st(8'h04, 8'h04);
        eng.addr(1'b0, 1'b0);
        st(8'h04, 8'h00);
        eng.addr(1'b1, 1'b0);
        eng.strobe(10'h004, 1'b0);
        st(8'h04, 8'h00);
    endtask
    task t_ua;
        eng.addr(1'b0, 1'b1);
        st(8'h02, 8'h00);
        apb(1'b1, 12'h004, 32'hF);
        eng.addr(1'b0, 1'b1);
        st(8'h02, 8'h02);
        apb(1'b1, 12'h018, 32'h0F0);
        st(8'h02, 8'h00);
        check("slave_addr", 32'h0F0, slave_address_register);
    endtask
    task t_tx;
        apb(1'b1, 12'h004, 32'h5);
        apb(1'b1, 12'h00C, 32'hA5);
        check("tx_byte", 32'hA5, tx_byte);
        check("tx_pending", 1, tx_pending);
        eng.strobe(10'h008, 1'b0);
        check("master_idle", 0, master_idle);
        st(8'h05, 8'h05);
        eng.strobe(10'h010, 1'b1);
        st(8'h25, 8'h20);
        check("master_idle", 1, master_idle);
    endtask
    task t_seq;
        int i;
        apb(1'b1, 12'h008, 32'h1F);
        check("seq_enable", 32'h1F, seq_enable);
        for (i = 0; i < 5; i++)
        begin
            check("master_idle", 0, master_idle);
            eng.strobe({5'h1 << i, 5'h0}, 1'b0);
        end
        check("master_idle", 1, master_idle);
    endtask
    task t_sp;
        apb(1'b1, 12'h004, 32'h7);
        eng.strobe(10'h001, 1'b0);
        st(8'h18, 8'h08);
        eng.strobe(10'h002, 1'b0);
        st(8'h18, 8'h10);
        apb(1'b1, 12'h004, 32'h6);
        st(8'h18, 8'h00);
    endtask
    // Reset in mid-run clears a seen start and the port enable bit
    task t_rst;
        apb(1'b1, 12'h004, 32'h7);
        eng.strobe(10'h001, 1'b0);
        st(8'h08, 8'h08);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        st(8'hFF, 8'h00);
        check("port_enable_bit", 0, port_enable_bit);
    endtask
    task t_edge;
        apb(1'b1, 12'h004, 32'h1);
        apb(1'b1, 12'h000, 32'hC0);
        check("edge", 1, tx_on_active_to_idle);
        check("smp", 1, sample_at_end);
        apb(1'b1, 12'h004, 32'h3);
        check("port_mode", 1, port_mode);
        check("smp", 0, sample_at_end);
        apb(1'b1, 12'h004, 32'h7);
        check("edge", 0, tx_on_active_to_idle);
        apb(1'b0, 12'h020, 32'h0);
        check("pslverr", 1, perr);
        check("prdata", 0, rd);
    endtask
    // Main sequence
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_rx();
        t_rw();
        t_ua();
        t_tx();
        t_seq();
        t_sp();
        t_rst();
        t_edge();
        end_of_test();
    end
endmodule

// ===== dv/spsf_engine_model.sv
// ----------------------------------------
// Serial engine stand-in for the port
// ----------------------------------------
module spsf_engine_model (
    input wire logic pclk,
    output logic ev_start = 1'b0,
    output logic ev_stop = 1'b0,
    output logic ev_ack = 1'b0,
    output logic ev_addr_match = 1'b0,
    output logic ev_addr_rw = 1'b0,
    output logic ev_addr_high = 1'b0,
    output logic rx_valid = 1'b0,
    output logic rx_is_data = 1'b0,
    output spsf_pkg::spsf_byte_t rx_byte = 8'hFF,
    output logic tx_begin = 1'b0,
    output logic tx_bits_done = 1'b0,
    output logic tx_is_data = 1'b0,
    output logic [4:0] seq_done = 5'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    import spsf_pkg::*;
    // Received byte; released lines show the inverse
    task rx(input spsf_byte_t b, input logic d);
        @(posedge pclk);
        rx_valid <= 1'b1;
        rx_byte <= b;
        rx_is_data <= d;
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_byte <= ~b;
        rx_is_data <= ~d;
        #1;
    endtask
    // Address match with direction and high-byte marks
    task addr(input logic rw, input logic hi);
        @(posedge pclk);
        ev_addr_match <= 1'b1;
        ev_addr_rw <= rw;
        ev_addr_high <= hi;
        @(posedge pclk);
        ev_addr_match <= 1'b0;
        ev_addr_rw <= ~rw;
        ev_addr_high <= 1'b0;
        #1;
    endtask
    // Strobes: seq_done, bits done, begin, ack, stop, start
    task strobe(input logic [9:0] v, input logic d);
        @(posedge pclk);
        {seq_done, tx_bits_done, tx_begin, ev_ack, ev_stop, ev_start} <= v;
        tx_is_data <= d;
        @(posedge pclk);
        {seq_done, tx_bits_done, tx_begin, ev_ack, ev_stop, ev_start} <=
            10'h000;
        tx_is_data <= ~d;
        #1;
    endtask
endmodule

// ===== dv/spsf_top_chk.sv
// ----------------------------------------
// Port-level checks of the status block
// ----------------------------------------
module spsf_top_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic tx_begin,
    input wire logic tx_pending,
    input wire logic [4:0] seq_done,
    input wire logic [4:0] seq_enable,
    input wire spsf_pkg::spsf_mode_e port_mode,
    input wire logic port_enable_bit,
    input wire logic tx_on_active_to_idle,
    input wire logic sample_at_end,
    input wire logic master_idle
);
    import spsf_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic wr_acc;
    logic rd_st;
    // Access-phase qualifiers
    assign wr_acc = psel && penable && pwrite;
    assign rd_st = psel && penable && !pwrite && paddr == 12'h000;
    a_idle_busy: assert property ((|seq_enable) |-> !master_idle)
        else $error("idle while a sequence is enabled");
    a_seq_clear: assert property ((|(seq_done & seq_enable))
        && !wr_acc |=> (seq_enable & $past(seq_done)) == 5'h0)
        else $error("sequence enable not cleared");
    a_seq_set: assert property (wr_acc && paddr == 12'h008
        && !(|seq_done)
        |=> seq_enable == ($past(seq_enable) | $past(pwdata[4:0])))
        else $error("sequence enable write lost");
    a_edge_i2c: assert property (port_mode[1] |-> !tx_on_active_to_idle)
        else $error("edge select active in two-wire mode");
    a_smp_master: assert property (port_mode != SPSF_SPI_MASTER
        |-> !sample_at_end)
        else $error("sample phase outside SPI master");
    a_tx_start: assert property (tx_begin && tx_pending
        && !(wr_acc && paddr == 12'h00C) |=> !tx_pending)
        else $error("pending byte not taken");
    a_flags_off: assert property (rd_st && !port_enable_bit
        && !$past(port_enable_bit) && !$past(port_enable_bit, 2)
        |-> prdata[4:3] == 2'h0)
        else $error("start or stop flag set while disabled");
    a_err_unmap: assert property (psel && penable && paddr >= 12'h01C
        |-> pslverr)
        else $error("no error on unmapped address");
    c_seq_done: cover property (|(seq_done & seq_enable));
    c_tx_start: cover property (tx_begin && tx_pending);
    c_flags_off: cover property (rd_st && !port_enable_bit);
endmodule

bind spsf_top spsf_top_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pslverr, .tx_begin, .tx_pending, .seq_done,
    .seq_enable, .port_mode, .port_enable_bit, .tx_on_active_to_idle,
    .sample_at_end, .master_idle);
